// [core/rx_irq_pkg.sv]
package rx_irq_pkg;

    // Register offsets
    localparam logic [7:0] PORT_SEL_OFFSET = 8'h4c;
    localparam logic [7:0] IRQ_EN_HIGH_OFFSET = 8'hd8;
    localparam logic [7:0] IRQ_EN_LOW_OFFSET = 8'hd9;
    localparam logic [7:0] IRQ_STATUS_HIGH_OFFSET = 8'hda;
    localparam logic [7:0] IRQ_STATUS_LOW_OFFSET = 8'hdb;

    // Values after reset
    localparam logic [7:0] PORT_SEL_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_HIGH_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_LOW_RESET = 8'h00;
    localparam logic [15:0] IRQ_FLAGS_RESET = 16'h0000;

    // Field positions in the high registers
    localparam int ENC_ERR_BIT = 2;
    localparam int SEQ_ERR_BIT = 1;
    localparam int CRC_ERR_BIT = 0;

    // Field positions in the low registers
    localparam int LINE_LEN_BIT = 6;
    localparam int LINE_CNT_BIT = 5;
    localparam int OVERFLOW_BIT = 4;
    localparam int PARITY_BIT = 2;
    localparam int PORT_VALID_BIT = 1;
    localparam int LOCK_BIT = 0;

    // Implemented bits; the rest are reserved and read as zero
    localparam logic [7:0] HIGH_BITS_MASK = 8'h07;
    localparam logic [7:0] LOW_BITS_MASK = 8'h77;

    // Flag vector is {low status, high status}; clearing groups
    localparam logic [15:0] CLR_BY_FIRST_MASK = 16'h0703;
    localparam logic [15:0] CLR_BY_SECOND_MASK = 16'h7004;

    // Width of measured line length and line count
    localparam int LINE_MEAS_W = 16;

    // One register access from the register engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Detection results of one receive port
    typedef struct packed {
        logic encoding_error;
        logic ctrl_chan_sequence_error;
        logic ctrl_chan_crc_error;
        logic rx_buffer_overflow;
        logic parity_error;
        logic port_valid;
        logic lock;
        logic line_meas_valid;
        logic [LINE_MEAS_W-1:0] line_length;
        logic [LINE_MEAS_W-1:0] line_count;
    } port_events_s;

endpackage : rx_irq_pkg

// [core/rx_port_irq.sv]
`timescale 1ns/1ps
`default_nettype none

module rx_port_irq #(
    parameter int NUM_PORTS = 4,
    parameter int PORT_IDX_W = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire rx_irq_pkg::reg_req_s reg_req,
    input wire logic port_status_first_rd,
    input wire logic port_status_second_rd,
    input wire rx_irq_pkg::port_events_s [NUM_PORTS-1:0] port_events,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    output logic [NUM_PORTS-1:0] port_irq_q
);

    // Address match helper
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
        addr_hit = (addr == offset);
    endfunction : addr_hit

    // Port index held in the select register
    function automatic logic [PORT_IDX_W-1:0] sel_field(input logic [7:0] value);
        sel_field = value[PORT_IDX_W-1:0];
    endfunction : sel_field

    // Change detector for a measurement that has a previous value
    function automatic logic meas_changed(
        input logic seen,
        input logic [rx_irq_pkg::LINE_MEAS_W-1:0] now_val,
        input logic [rx_irq_pkg::LINE_MEAS_W-1:0] last_val
    );
        meas_changed = seen && (now_val != last_val);
    endfunction : meas_changed

    logic [7:0] port_sel_q;
    logic [PORT_IDX_W-1:0] sel_idx;
    logic sel_in_range;
    logic [7:0] en_high_q [NUM_PORTS];
    logic [7:0] en_low_q [NUM_PORTS];
    logic [15:0] flags [NUM_PORTS];
    logic [7:0] rd_mux;

    // Port currently addressed by register accesses
    assign sel_idx = sel_field(port_sel_q);
    assign sel_in_range = (32'(sel_idx) < NUM_PORTS);

    // Port select register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port_sel_q <= rx_irq_pkg::PORT_SEL_RESET;
        end else if (reg_req.wr && addr_hit(reg_req.addr, rx_irq_pkg::PORT_SEL_OFFSET)) begin
            port_sel_q <= {{(8 - PORT_IDX_W){1'b0}}, sel_field(reg_req.wdata)};
        end
    end

    // High enable registers, one copy per port
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                en_high_q[p] <= rx_irq_pkg::IRQ_EN_HIGH_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (reg_req.wr && addr_hit(reg_req.addr, rx_irq_pkg::IRQ_EN_HIGH_OFFSET)
                    && sel_in_range && (32'(sel_idx) == p)) begin
                    en_high_q[p] <= reg_req.wdata & rx_irq_pkg::HIGH_BITS_MASK;
                end
            end
        end
    end

    // Low enable registers, one copy per port; reserved bits stay zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                en_low_q[p] <= rx_irq_pkg::IRQ_EN_LOW_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (reg_req.wr && addr_hit(reg_req.addr, rx_irq_pkg::IRQ_EN_LOW_OFFSET)
                    && sel_in_range && (32'(sel_idx) == p)) begin
                    en_low_q[p] <= reg_req.wdata & rx_irq_pkg::LOW_BITS_MASK;
                end
            end
        end
    end

    // Per-port event capture, change detection and interrupt request
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        logic primed_q;
        logic lock_prev_q;
        logic valid_prev_q;
        logic meas_seen_q;
        logic [rx_irq_pkg::LINE_MEAS_W-1:0] len_last_q;
        logic [rx_irq_pkg::LINE_MEAS_W-1:0] cnt_last_q;
        logic lock_chg;
        logic valid_chg;
        logic len_chg;
        logic cnt_chg;
        logic selected;
        logic [15:0] set_vec;
        logic [15:0] clr_vec;

        // Previous levels; the first cycle after reset only primes them
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                primed_q <= 1'b0;
                lock_prev_q <= 1'b0;
                valid_prev_q <= 1'b0;
            end else begin
                primed_q <= 1'b1;
                lock_prev_q <= port_events[g].lock;
                valid_prev_q <= port_events[g].port_valid;
            end
        end

        // Last line measurement; no change is seen before the first one
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                meas_seen_q <= 1'b0;
                len_last_q <= '0;
                cnt_last_q <= '0;
            end else if (port_events[g].line_meas_valid) begin
                meas_seen_q <= 1'b1;
                len_last_q <= port_events[g].line_length;
                cnt_last_q <= port_events[g].line_count;
            end
        end

        // Level changes and measurement changes
        assign lock_chg = primed_q && (port_events[g].lock != lock_prev_q);
        assign valid_chg = primed_q && (port_events[g].port_valid != valid_prev_q);
        assign len_chg = port_events[g].line_meas_valid
            && meas_changed(meas_seen_q, port_events[g].line_length, len_last_q);
        assign cnt_chg = port_events[g].line_meas_valid
            && meas_changed(meas_seen_q, port_events[g].line_count, cnt_last_q);

        // Flag set vector, laid out as {low status, high status}
        always_comb begin
            set_vec = '0;
            set_vec[rx_irq_pkg::ENC_ERR_BIT] = port_events[g].encoding_error;
            set_vec[rx_irq_pkg::SEQ_ERR_BIT] = port_events[g].ctrl_chan_sequence_error;
            set_vec[rx_irq_pkg::CRC_ERR_BIT] = port_events[g].ctrl_chan_crc_error;
            set_vec[8 + rx_irq_pkg::LINE_LEN_BIT] = len_chg;
            set_vec[8 + rx_irq_pkg::LINE_CNT_BIT] = cnt_chg;
            set_vec[8 + rx_irq_pkg::OVERFLOW_BIT] = port_events[g].rx_buffer_overflow;
            set_vec[8 + rx_irq_pkg::PARITY_BIT] = port_events[g].parity_error;
            set_vec[8 + rx_irq_pkg::PORT_VALID_BIT] = valid_chg;
            set_vec[8 + rx_irq_pkg::LOCK_BIT] = lock_chg;
        end

        // Clearing follows status reads of the selected port only
        assign selected = sel_in_range && (32'(sel_idx) == g);
        always_comb begin
            clr_vec = '0;
            if (selected && port_status_first_rd) begin
                clr_vec = clr_vec | rx_irq_pkg::CLR_BY_FIRST_MASK;
            end
            if (selected && port_status_second_rd) begin
                clr_vec = clr_vec | rx_irq_pkg::CLR_BY_SECOND_MASK;
            end
        end

        // Sticky status flags
        sticky_flags #(
            .WIDTH(16)
        ) u_flags (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .set_vec(set_vec),
            .clr_vec(clr_vec),
            .flags_q(flags[g])
        );

        // Interrupt request: any flag whose enable is set
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                port_irq_q[g] <= 1'b0;
            end else begin
                port_irq_q[g] <= |(flags[g] & {en_low_q[g], en_high_q[g]});
            end
        end
    end

    // Read data selection for the addressed port
    always_comb begin
        rd_mux = 8'h00;
        if (addr_hit(reg_req.addr, rx_irq_pkg::PORT_SEL_OFFSET)) begin
            rd_mux = port_sel_q;
        end else if (sel_in_range) begin
            unique case (reg_req.addr)
                rx_irq_pkg::IRQ_EN_HIGH_OFFSET: begin
                    rd_mux = en_high_q[sel_idx] & rx_irq_pkg::HIGH_BITS_MASK;
                end
                rx_irq_pkg::IRQ_EN_LOW_OFFSET: begin
                    rd_mux = en_low_q[sel_idx] & rx_irq_pkg::LOW_BITS_MASK;
                end
                rx_irq_pkg::IRQ_STATUS_HIGH_OFFSET: begin
                    rd_mux = flags[sel_idx][7:0] & rx_irq_pkg::HIGH_BITS_MASK;
                end
                rx_irq_pkg::IRQ_STATUS_LOW_OFFSET: begin
                    rd_mux = flags[sel_idx][15:8] & rx_irq_pkg::LOW_BITS_MASK;
                end
                default: begin
                    rd_mux = 8'h00;
                end
            endcase
        end
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_req.rd;
            rd_data_q <= reg_req.rd ? rd_mux : 8'h00;
        end
    end

endmodule : rx_port_irq

`default_nettype wire

// [core/sticky_flags.sv]
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set_vec,
    input wire logic [WIDTH-1:0] clr_vec,
    output logic [WIDTH-1:0] flags_q
);

    // Set wins over clear in the same cycle; flags hold otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_vec) | set_vec;
        end
    end

endmodule : sticky_flags

`default_nettype wire

// [testbench/reg_host.sv]
`timescale 1ns/1ps
`default_nettype none
module reg_host (
    input wire logic sys_clk,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    output var rx_irq_pkg::reg_req_s reg_req,
    output logic first_rd,
    output logic second_rd
);
    // Idle bus at time zero
    initial begin
        reg_req = '0;
        first_rd = 1'b0;
        second_rd = 1'b0;
    end
    // One byte access; the answer is registered on the taking edge and read at the falling edge half a cycle later
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
        output logic ok);
        @(posedge sys_clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '0;
        @(negedge sys_clk);
        q = rd_data_q;
        ok = (rd_valid_q === !w);
    endtask : access
    // Host read of the first or second port status register
    task automatic clear_read(input logic second);
        @(posedge sys_clk);
        first_rd <= !second;
        second_rd <= second;
        @(posedge sys_clk);
        first_rd <= 1'b0;
        second_rd <= 1'b0;
    endtask : clear_read
endmodule : reg_host
`default_nettype wire

// [testbench/rx_port_irq_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_port_irq_chk #(
    parameter int NUM_PORTS = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire rx_irq_pkg::reg_req_s reg_req,
    input wire logic port_status_first_rd,
    input wire logic port_status_second_rd,
    input wire rx_irq_pkg::port_events_s [NUM_PORTS-1:0] port_events,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic [NUM_PORTS-1:0] port_irq_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // No write or clear in this cycle
    wire logic quiet = !reg_req.wr && !port_status_first_rd && !port_status_second_rd;
    // Read answer timing, reserved bits, outputs after reset and irq stability while quiet
    chk_read_answered: assert property (reg_req.rd |=> rd_valid_q) else $error("read not answered");
    chk_no_stray_valid: assert property (!reg_req.rd |=> !rd_valid_q) else $error("stray read valid");
    chk_idle_data_zero: assert property (!rd_valid_q |-> rd_data_q == 8'h00) else $error("idle data not zero");
    chk_high_en_reserved: assert property (reg_req.rd && reg_req.addr == 8'hd8 |=> rd_data_q[7:3] == 5'h00)
        else $error("high enable reserved bits set");
    chk_low_en_reserved: assert property (reg_req.rd && reg_req.addr == 8'hd9 |=> !rd_data_q[7] && !rd_data_q[3])
        else $error("low enable reserved bits set");
    chk_high_st_reserved: assert property (reg_req.rd && reg_req.addr == 8'hda |=> rd_data_q[7:3] == 5'h00)
        else $error("high status reserved bits set");
    chk_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 8'h00 |=> rd_data_q == 8'h00)
        else $error("unmapped read not zero");
    chk_reset_outputs: assert property ($rose(rst_n) |-> port_irq_q == '0 && !rd_valid_q)
        else $error("outputs not cleared by reset");
    chk_irq_holds_quiet: assert property ((quiet && port_events == $past(port_events)) [*3] |-> $stable(port_irq_q))
        else $error("irq moved without cause");
endmodule : rx_port_irq_chk
bind rx_port_irq rx_port_irq_chk #(.NUM_PORTS(NUM_PORTS)) chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_req(reg_req), .port_status_first_rd(port_status_first_rd), .port_status_second_rd(port_status_second_rd),
    .port_events(port_events), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .port_irq_q(port_irq_q));
`default_nettype wire

// [testbench/tb_rx_port_irq.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rx_port_irq;
    logic sys_clk;
    logic rst_n;
    rx_irq_pkg::reg_req_s reg_req;
    logic first_rd;
    logic second_rd;
    rx_irq_pkg::port_events_s [3:0] ev;
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    logic [3:0] port_irq_q;
    int mismatches = 0;
    int n_tests = 0;
    int bit_tab [9] = '{2, 1, 0, 6, 5, 4, 2, 1, 0};
    logic [7:0] q;
    logic [7:0] hi;
    logic [7:0] lo;
    logic ok;
    logic sec;
    rx_port_irq #(.NUM_PORTS(4), .PORT_IDX_W(2)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
        .port_status_first_rd(first_rd), .port_status_second_rd(second_rd), .port_events(ev),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .port_irq_q(port_irq_q));
    reg_host host (.sys_clk(sys_clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .reg_req(reg_req),
        .first_rd(first_rd), .second_rd(second_rd));
    // 25 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = !sys_clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00, q, ok);
        check({7'h00, ok}, 8'h01);
        check(q, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q, ok);
        check({7'h00, ok}, 8'h01);
    endtask : wr
    task automatic irq_is(input logic [3:0] exp);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({4'h0, port_irq_q}, {4'h0, exp});
    endtask : irq_is
    // One event of source i on port 1: a one-cycle pulse, or a level toggle for sources 7 and 8
    task automatic fire(input int i);
        @(posedge sys_clk);
        case (i)
            0: ev[1].encoding_error <= 1'b1;
            1: ev[1].ctrl_chan_sequence_error <= 1'b1;
            2: ev[1].ctrl_chan_crc_error <= 1'b1;
            3: ev[1].line_length <= ev[1].line_length + 16'h0001;
            4: ev[1].line_count <= ev[1].line_count + 16'h0001;
            5: ev[1].rx_buffer_overflow <= 1'b1;
            6: ev[1].parity_error <= 1'b1;
            7: ev[1].port_valid <= !ev[1].port_valid;
            default: ev[1].lock <= !ev[1].lock;
        endcase
        ev[1].line_meas_valid <= (i == 3 || i == 4);
        @(posedge sys_clk);
        ev[1].encoding_error <= 1'b0;
        ev[1].ctrl_chan_sequence_error <= 1'b0;
        ev[1].ctrl_chan_crc_error <= 1'b0;
        ev[1].rx_buffer_overflow <= 1'b0;
        ev[1].parity_error <= 1'b0;
        ev[1].line_meas_valid <= 1'b0;
    endtask : fire
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        ev = '0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'hd8, 8'h00);
        rd(8'hd9, 8'h00);
        rd(8'hda, 8'h00);
        wr(8'hd8, 8'hff);
        rd(8'hd8, 8'h07);
        wr(8'hd9, 8'hff);
        rd(8'hd9, 8'h77);
        wr(8'hda, 8'hff);
        rd(8'hda, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h4c, 8'h01);
        rd(8'h4c, 8'h01);
        rd(8'hd8, 8'h00);
        fire(3);
        $display("test registers done");
        // Each source: flag without enable, then enable, wrong clear, right clear
        for (int i = 0; i < 9; i++) begin
            hi = (i < 3) ? 8'h01 << bit_tab[i] : 8'h00;
            lo = (i < 3) ? 8'h00 : 8'h01 << bit_tab[i];
            sec = (i == 0) || (i > 2 && i < 6);
            fire(i);
            irq_is(4'h0);
            rd(8'hda, hi);
            rd(8'hdb, lo);
            wr(8'hd8, hi);
            wr(8'hd9, lo);
            irq_is(4'h2);
            host.clear_read(!sec);
            rd(8'hda, hi);
            rd(8'hdb, lo);
            host.clear_read(sec);
            rd(8'hda, 8'h00);
            rd(8'hdb, 8'h00);
            irq_is(4'h0);
            $display("test source %0d done", i);
        end
        // Clears reach only the selected port
        fire(0);
        wr(8'h4c, 8'h00);
        rd(8'h4c, 8'h00);
        host.clear_read(1'b1);
        wr(8'h4c, 8'h01);
        rd(8'hda, 8'h04);
        host.clear_read(1'b1);
        rd(8'hda, 8'h00);
        $display("test select clear done");
        // Mid-run reset returns select and port 0 enables to zero
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h4c, 8'h00);
        rd(8'hd8, 8'h00);
        rd(8'hd9, 8'h00);
        rd(8'hda, 8'h00);
        irq_is(4'h0);
        $display("test reset done");
        close_out();
    end
endmodule : tb_rx_port_irq
`default_nettype wire
